// ==== include/flc_pkg.sv ====
package flc_pkg;

    // memory (32-bit) layout
    localparam int MEM_SIGN_BIT    = 15;
    localparam int MEM_EXP_HI      = 14;
    localparam int MEM_EXP_LO      = 7;
    localparam int MEM_FHI_HI      = 6;
    localparam int MEM_FLO_HI      = 31;
    localparam int MEM_FLO_LO      = 16;

    // register (64-bit) layout
    localparam int REG_SIGN_BIT    = 63;
    localparam int REG_EXP_HI      = 62;
    localparam int REG_EXP_LO      = 52;
    localparam int REG_FHI_HI      = 51;
    localparam int REG_FHI_LO      = 45;
    localparam int REG_FLO_HI      = 44;
    localparam int REG_FLO_LO      = 29;
    localparam int REG_ZERO_HI     = 28;

    localparam int MEM_EXP_W       = 8;
    localparam int REG_EXP_W       = 11;
    localparam int VA_W_MIN        = 43;

    localparam logic [2:0] EXP_INS_NEG = 3'h0;
    localparam logic [2:0] EXP_INS_POS = 3'h7;

    // access sizes: log2 of bytes
    typedef enum logic [1:0] {
        FLC_SZ_BYTE,
        FLC_SZ_WORD,
        FLC_SZ_LONG,
        FLC_SZ_QUAD
    } flc_size_e;

    typedef enum logic [1:0] {
        FLC_OP_NONE,
        FLC_OP_LOAD,
        FLC_OP_STORE,
        FLC_OP_CHECK
    } flc_op_e;

    // result classification of an operand
    typedef enum logic [1:0] {
        FLC_CL_ZERO,
        FLC_CL_NORMAL,
        FLC_CL_RESERVED
    } flc_class_e;

    // byte-numbered alignment check: size 2**n needs n low zero bits
    function automatic logic flc_aligned(input logic [2:0] addr_lo, input flc_size_e sz);
        case (sz)
            FLC_SZ_BYTE: flc_aligned = 1'b1;
            FLC_SZ_WORD: flc_aligned = (addr_lo[0] == 1'b0);
            FLC_SZ_LONG: flc_aligned = (addr_lo[1:0] == 2'h0);
            FLC_SZ_QUAD: flc_aligned = (addr_lo == 3'h0);
            default:     flc_aligned = 1'b0;
        endcase
    endfunction

    // classify from sign and exponent-is-zero
    function automatic flc_class_e flc_classify(input logic sign, input logic exp_zero);
        if (!exp_zero)
            flc_classify = FLC_CL_NORMAL;
        else if (sign)
            flc_classify = FLC_CL_RESERVED;
        else
            flc_classify = FLC_CL_ZERO;
    endfunction

endpackage

// ==== include/flc_conv_if.sv ====
interface flc_conv_if;
    import flc_pkg::*;
    logic [31:0] mem_word;
    logic [63:0] reg_word;
    logic [63:0] load_val;
    logic [31:0] store_val;
    flc_class_e  load_class;
    flc_class_e  store_class;

    modport conv (
        input  mem_word,
        input  reg_word,
        output load_val,
        output store_val,
        output load_class,
        output store_class
    );
    modport user (
        output mem_word,
        output reg_word,
        input  load_val,
        input  store_val,
        input  load_class,
        input  store_class
    );
endinterface

// ==== design/flc_convert.sv ====
module flc_convert
    import flc_pkg::*;
(
    flc_conv_if.conv cv
);
    logic        m_sign;
    logic [7:0]  m_exp;
    logic [6:0]  m_fhi;
    logic [15:0] m_flo;
    logic [2:0]  ins;

    assign m_sign = cv.mem_word[MEM_SIGN_BIT];
    assign m_exp  = cv.mem_word[MEM_EXP_HI:MEM_EXP_LO];
    assign m_fhi  = cv.mem_word[MEM_FHI_HI:0];
    assign m_flo  = cv.mem_word[MEM_FLO_HI:MEM_FLO_LO];

    // exponent widening by bit insertion only
    always_comb
    begin
        if (m_exp[7])
            ins = EXP_INS_NEG; // RQ2
        else if (m_exp[6:0] != 7'h0)
            ins = EXP_INS_POS; // RQ2
        else
            ins = EXP_INS_NEG; // RQ2
    end

    // pure permutation, no rounding or range check
    assign cv.load_val = {m_sign, m_exp[7], ins, m_exp[6:0], m_fhi, m_flo,
                          29'h0}; // RQ1 RQ3 RQ6 RQ21
    assign cv.load_class = flc_classify(m_sign, m_exp == 8'h0); // RQ8 RQ9

    // store drops register bits 61:59 and 28:0 unchecked
    assign cv.store_val = {cv.reg_word[REG_FLO_HI:REG_FLO_LO],
                           cv.reg_word[REG_SIGN_BIT],
                           cv.reg_word[REG_EXP_HI],
                           cv.reg_word[58:REG_EXP_LO],
                           cv.reg_word[REG_FHI_HI:REG_FHI_LO]}; // RQ4 RQ5 RQ6 RQ21
    assign cv.store_class = flc_classify(cv.reg_word[REG_SIGN_BIT],
                                         cv.reg_word[REG_EXP_HI:REG_EXP_LO] == 11'h0);
endmodule

// ==== design/flc_addr_check.sv ====
module flc_addr_check
    import flc_pkg::*;
#(
    parameter int VA_W = 64
)
(
    input  wire logic [63:0] addr_i,
    input  wire flc_size_e   size_i,
    output logic             aligned_o,
    output logic             va_ok_o
);
    localparam int VA_USED = (VA_W < VA_W_MIN) ? VA_W_MIN : VA_W; // RQ17

    assign aligned_o = flc_aligned(addr_i[2:0], size_i); // RQ19

    // upper address bits must be a sign extension of the implemented space
    generate
        if (VA_USED >= 64)
        begin : g_full
            assign va_ok_o = 1'b1;
        end
        else
        begin : g_part
            assign va_ok_o = (&addr_i[63:VA_USED-1]) | ~(|addr_i[63:VA_USED-1]); // RQ17
        end
    endgenerate
endmodule

// ==== design/flc_top.sv ====
// How it works
// RQ1 - load widens exponent, zeroes low fraction
// RQ2 - exponent insert 000, 111, or zero
// RQ3 - register sign 63, exponent 62:52, fraction below
// RQ4 - memory sign 15, exponent 14:7, split fraction
// RQ5 - store reorders, drops bits 61:59, 28:0
// RQ6 - loads and stores only permute bits
// RQ7 - zero results are all-zero words
// RQ8 - sign one, exponent zero: reserved, arithmetic trap
// RQ9 - exponent zero, sign zero means zero
// RQ10 - nonzero must-clear field raises illegal operand
// RQ11 - read-as-zero fields always read zero
// RQ12 - ignored field writes change nothing
// RQ13 - software should clear advised-clear fields
// RQ14 - unpredictable results use only accessible state
// RQ15 - undefined operation never hangs processor
// RQ16 - only kernel mode reaches undefined operations
// RQ17 - byte addresses, 64-bit, at least 43 bits
// RQ18 - address names the byte holding bit 0
// RQ19 - size 2**N aligned needs N zeros
// RQ20 - longword sign 31, quadword sign 63
// RQ21 - conversion is combinational, same cycle
module flc_top
    import flc_pkg::*;
#(
    parameter int VA_W = 64
)
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // request
    input  wire logic        req_i,
    input  wire flc_op_e     op_i,
    input  wire flc_size_e   size_i,
    input  wire logic [63:0] addr_i,
    input  wire logic        kernel_i,
    input  wire logic        undef_op_i,
    // data
    input  wire logic [31:0] mem_rd_i,
    input  wire logic [63:0] reg_rd_i,
    input  wire logic [63:0] must_clear_field_i,
    input  wire logic [63:0] write_ignored_field_i,
    input  wire logic [63:0] field_wr_i,
    // results
    output logic             valid_o,
    output logic [63:0]      reg_wr_o,
    output logic [31:0]      mem_wr_o,
    output logic             misaligned_o,
    output logic             va_fault_o,
    output logic             arith_exc_o,
    output logic             illegal_op_exc_o,
    output logic             priv_exc_o,
    output logic             is_zero_o,
    output logic             long_neg_o,
    output logic             quad_neg_o,
    output logic [63:0]      field_rd_o,
    output logic [63:0]      lane_data_o
);
    ////////////////////////////////////////////////////////////////////////
    flc_conv_if cv ();
    logic aligned;
    logic va_ok;
    logic [63:0] held_field_reg;
    logic [63:0] held_field_next;
    logic [63:0] lanes;
    logic        go;

    assign cv.mem_word = mem_rd_i;
    assign cv.reg_word = reg_rd_i;

    flc_convert u_conv (
        .cv (cv.conv)
    );

    flc_addr_check #(
        .VA_W (VA_W)
    ) u_addr (
        .addr_i    (addr_i),
        .size_i    (size_i),
        .aligned_o (aligned),
        .va_ok_o   (va_ok)
    );

    // an undefined op from user mode is trapped, never executed
    assign go = req_i && (kernel_i || !undef_op_i); // RQ16

    ////////////////////////////////////////////////////////////////////////
    // field register: ignored bits keep their value on write
    always_comb
    begin
        held_field_next = held_field_reg;
        if (go && op_i == FLC_OP_STORE)
            held_field_next = (held_field_reg & write_ignored_field_i)
                            | (field_wr_i & ~write_ignored_field_i); // RQ12
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            held_field_reg <= 64'h0;
        else
            held_field_reg <= held_field_next;
    end

    // byte lane order: address names the byte holding bit 0
    always_comb
    begin
        lanes = 64'h0;
        case (addr_i[2:0])
            3'h0: lanes = reg_rd_i;
            3'h1: lanes = {reg_rd_i[55:0], 8'h0}; // RQ18
            3'h2: lanes = {reg_rd_i[47:0], 16'h0};
            3'h3: lanes = {reg_rd_i[39:0], 24'h0};
            3'h4: lanes = {reg_rd_i[31:0], 32'h0};
            3'h5: lanes = {reg_rd_i[23:0], 40'h0};
            3'h6: lanes = {reg_rd_i[15:0], 48'h0};
            3'h7: lanes = {reg_rd_i[7:0], 56'h0};
            default: lanes = 64'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // status pulses, one per request
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            valid_o          <= 1'b0;
            misaligned_o     <= 1'b0;
            va_fault_o       <= 1'b0;
            arith_exc_o      <= 1'b0;
            illegal_op_exc_o <= 1'b0;
            priv_exc_o       <= 1'b0;
            is_zero_o        <= 1'b0;
        end
        else
        begin
            // every request finishes next cycle, so nothing can hang
            valid_o          <= req_i; // RQ15
            misaligned_o     <= req_i && !aligned; // RQ19
            va_fault_o       <= req_i && !va_ok; // RQ17
            priv_exc_o       <= req_i && undef_op_i && !kernel_i; // RQ16
            illegal_op_exc_o <= go && ((reg_rd_i & must_clear_field_i) != 64'h0); // RQ10
            arith_exc_o      <= go && op_i == FLC_OP_CHECK
                                && cv.store_class == FLC_CL_RESERVED; // RQ8
            is_zero_o        <= go && (op_i == FLC_OP_LOAD
                                ? cv.load_class == FLC_CL_ZERO
                                : cv.store_class == FLC_CL_ZERO); // RQ9
        end
    end

    // data results
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            reg_wr_o    <= 64'h0;
            mem_wr_o    <= 32'h0;
            lane_data_o <= 64'h0;
        end
        else if (go)
        begin
            // a zero datum is stored as the canonical all-zero word
            if (op_i == FLC_OP_LOAD)
                reg_wr_o <= (cv.load_class == FLC_CL_ZERO) ? 64'h0 : cv.load_val; // RQ7
            // outputs use only the caller's own operands
            if (op_i == FLC_OP_STORE)
                mem_wr_o <= (cv.store_class == FLC_CL_ZERO) ? 32'h0 : cv.store_val; // RQ7 RQ14
            lane_data_o <= lanes;
        end
    end

    // integer sign views
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            long_neg_o <= 1'b0;
            quad_neg_o <= 1'b0;
            field_rd_o <= 64'h0;
        end
        else
        begin
            long_neg_o <= reg_rd_i[31]; // RQ20
            quad_neg_o <= reg_rd_i[63]; // RQ20
            // read-as-zero positions (must-clear mask) always return zero
            field_rd_o <= held_field_next & ~must_clear_field_i; // RQ11
        end
    end
endmodule

// ==== dv/flc_top_sva.sv ====
module flc_top_sva
    import flc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        req_i,
    input wire flc_op_e     op_i,
    input wire flc_size_e   size_i,
    input wire logic [63:0] addr_i,
    input wire logic        kernel_i,
    input wire logic        undef_op_i,
    input wire logic [31:0] mem_rd_i,
    input wire logic [63:0] reg_rd_i,
    input wire logic        valid_o,
    input wire logic [63:0] reg_wr_o,
    input wire logic [31:0] mem_wr_o,
    input wire logic        misaligned_o,
    input wire logic        arith_exc_o,
    input wire logic        priv_exc_o,
    input wire logic        long_neg_o,
    input wire logic        quad_neg_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic go;
    logic ld;
    assign go = req_i && (kernel_i || !undef_op_i);
    assign ld = go && op_i == FLC_OP_LOAD;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    a_valid_on_go: assert property (go |=> valid_o) else $error("no valid after request");
    a_valid_quiet: assert property (!req_i |=> !valid_o) else $error("valid without request");
    a_priv_refuse: assert property (req_i && undef_op_i && !kernel_i |=>
        priv_exc_o && $stable(reg_wr_o) && $stable(mem_wr_o))
        else $error("refused request not refused");
    a_load_zero: assert property (ld && mem_rd_i[15:7] == 9'h0 |=> reg_wr_o == 64'h0)
        else $error("zero load not all zero");
    a_load_tail: assert property (ld |=> reg_wr_o[28:0] == 29'h0)
        else $error("low fraction not clear");
    a_load_neg_ins: assert property (ld && mem_rd_i[14] |=> reg_wr_o[61:59] == 3'h0
        && reg_wr_o[63] == $past(mem_rd_i[15])) else $error("exponent insert wrong");
    a_load_pos_ins: assert property (ld && !mem_rd_i[14] && mem_rd_i[13:7] != 7'h0 |=>
        reg_wr_o[61:52] == {3'h7, $past(mem_rd_i[13:7])}) else $error("exponent insert wrong");
    a_store_order: assert property (go && op_i == FLC_OP_STORE && reg_rd_i[62] |=>
        mem_wr_o == {$past(reg_rd_i[44:29]), $past(reg_rd_i[63:62]), $past(reg_rd_i[58:45])})
        else $error("store order wrong");
    a_arith_reserved: assert property (go && op_i == FLC_OP_CHECK && reg_rd_i[63] &&
        reg_rd_i[62:52] == 11'h0 |=> arith_exc_o) else $error("reserved operand not trapped");
    a_long_misalign: assert property (ld && size_i == FLC_SZ_LONG && addr_i[1:0] != 2'h0
        |=> misaligned_o) else $error("misaligned longword not flagged");
    a_sign_track: assert property (1'b1 |=> long_neg_o == $past(reg_rd_i[31]) &&
        quad_neg_o == $past(reg_rd_i[63])) else $error("sign flags wrong");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind flc_top flc_top_sva chk_u (
    .clk_i        (clk_i),
    .nrst_i       (nrst_i),
    .req_i        (req_i),
    .op_i         (op_i),
    .size_i       (size_i),
    .addr_i       (addr_i),
    .kernel_i     (kernel_i),
    .undef_op_i   (undef_op_i),
    .mem_rd_i     (mem_rd_i),
    .reg_rd_i     (reg_rd_i),
    .valid_o      (valid_o),
    .reg_wr_o     (reg_wr_o),
    .mem_wr_o     (mem_wr_o),
    .misaligned_o (misaligned_o),
    .arith_exc_o  (arith_exc_o),
    .priv_exc_o   (priv_exc_o),
    .long_neg_o   (long_neg_o),
    .quad_neg_o   (quad_neg_o)
);

// ==== dv/flc_far_model.sv ====
module flc_far_model
(
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        req_i,
    input  wire logic [31:0] mem_i,
    input  wire logic [63:0] reg_i,
    output logic [31:0]      mem_rd_o,
    output logic [63:0]      reg_rd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem_last_reg;
    logic [63:0] reg_last_reg;
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mem_last_reg <= 32'h0;
            reg_last_reg <= 64'h0;
        end
        else if (req_i)
        begin
            mem_last_reg <= mem_i;
            reg_last_reg <= reg_i;
        end
    end
    // idle buses show the inverse of the last word
    assign mem_rd_o = req_i ? mem_i : ~mem_last_reg;
    assign reg_rd_o = req_i ? reg_i : ~reg_last_reg;
endmodule

// ==== dv/tb_float_load_store_format_convert.sv ====
module tb_float_load_store_format_convert;
    import flc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    int          err_total;
    int          comparisons;
    logic        clk_i;
    logic        nrst_i;
    logic        req;
    logic        kern;
    logic        undef;
    flc_op_e     op;
    flc_size_e   sz;
    logic [63:0] addr;
    logic [31:0] mem_v;
    logic [63:0] reg_v;
    logic [31:0] mem_rd;
    logic [63:0] reg_rd;
    logic        valid, misal, vaf, arith, priv, zero, lneg, qneg;
    logic [63:0] reg_wr;
    logic [63:0] lane;
    logic        illop;
    logic [63:0] fld;
    logic [63:0] mc;
    logic [63:0] write_ignored_field;
    logic [63:0] fw;
    logic [31:0] mem_wr;
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    flc_far_model far_u (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req), .mem_i(mem_v),
        .reg_i(reg_v), .mem_rd_o(mem_rd), .reg_rd_o(reg_rd));
    flc_top #(.VA_W(43)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req), .op_i(op),
        .size_i(sz), .addr_i(addr), .kernel_i(kern), .undef_op_i(undef), .mem_rd_i(mem_rd),
        .reg_rd_i(reg_rd), .must_clear_field_i(mc), .write_ignored_field_i(write_ignored_field),
        .field_wr_i(fw), .valid_o(valid), .reg_wr_o(reg_wr), .mem_wr_o(mem_wr),
        .misaligned_o(misal), .va_fault_o(vaf), .arith_exc_o(arith), .illegal_op_exc_o(illop),
        .priv_exc_o(priv), .is_zero_o(zero), .long_neg_o(lneg), .quad_neg_o(qneg),
        .field_rd_o(fld), .lane_data_o(lane));
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic issue(input flc_op_e o, input flc_size_e s, input logic [63:0] a,
        input logic [31:0] m, input logic [63:0] r, input logic k, input logic u);
        @(negedge clk_i);
        op = o;
        sz = s;
        {req, addr, mem_v, reg_v, kern, undef} = {1'b1, a, m, r, k, u};
        @(negedge clk_i);
        req = 1'b0;
    endtask
    function automatic logic [63:0] ld_ref(input logic [31:0] m);
        logic [10:0] e;
        e = m[14] ? {4'h8, m[13:7]} : (m[13:7] != 7'h0 ? {4'h7, m[13:7]} : 11'h0);
        ld_ref = (m[15:7] == 9'h0) ? 64'h0 : {m[15], e, m[6:0], m[31:16], 29'h0};
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_load();
        logic [31:0] t [6];
        t = '{32'h1234_c0aa, 32'hffff_7fff, 32'h0001_0080, 32'h5555_0011, 32'h0000_8005,
            32'habcd_4000};
        foreach (t[i])
        begin
            issue(FLC_OP_LOAD, FLC_SZ_LONG, 64'h0, t[i], 64'h0, 1'b0, 1'b0);
            chk("load value", ld_ref(t[i]), reg_wr);
            chk("zero flag", {63'h0, t[i][15:7] == 9'h0}, {63'h0, zero});
            chk("valid", 64'h1, {63'h0, valid});
        end
    endtask
    task automatic t_priv();
        issue(FLC_OP_LOAD, FLC_SZ_LONG, 64'h0, 32'h0000_4080, 64'h0, 1'b0, 1'b1);
        chk("priv user", 64'h1, {63'h0, priv});
        chk("held load", ld_ref(32'habcd_4000), reg_wr);
        issue(FLC_OP_LOAD, FLC_SZ_LONG, 64'h0, 32'h0000_4080, 64'h0, 1'b1, 1'b1);
        chk("priv kernel", 64'h0, {63'h0, priv});
        chk("kernel load", ld_ref(32'h0000_4080), reg_wr);
    endtask
    task automatic t_store();
        logic [63:0] t [2];
        t = '{64'h7abc_def0_1234_5678, 64'hf800_0000_1fff_ffff};
        foreach (t[i])
        begin
            issue(FLC_OP_STORE, FLC_SZ_LONG, 64'h0, 32'h0, t[i], 1'b0, 1'b0);
            chk("store", {32'h0, t[i][44:29], t[i][63:62], t[i][58:45]}, {32'h0, mem_wr});
        end
    endtask
    task automatic t_align();
        for (int s = 0; s < 4; s++)
        begin
            for (int a = 0; a < 8; a += 3)
            begin
                issue(FLC_OP_LOAD, flc_size_e'(s), 64'(a), 32'h4080, 64'h0102_0304_0506_0708,
                    1'b1, 1'b0);
                chk("misaligned", {63'h0, (a & ((1 << s) - 1)) != 0}, {63'h0, misal});
                chk("lane", 64'h0102_0304_0506_0708 << (8 * a), lane);
            end
        end
        issue(FLC_OP_LOAD, FLC_SZ_QUAD, 64'h0000_4000_0000_0000, 32'h4080, 64'h0, 1'b1, 1'b0);
        chk("va fault", 64'h1, {63'h0, vaf});
        issue(FLC_OP_LOAD, FLC_SZ_QUAD, 64'hffff_fc00_0000_0000, 32'h4080, 64'h0, 1'b1, 1'b0);
        chk("va ok", 64'h0, {63'h0, vaf});
    endtask
    task automatic t_check();
        issue(FLC_OP_CHECK, FLC_SZ_QUAD, 64'h0, 32'h0, 64'h8000_0000_0000_0000, 1'b0, 1'b0);
        chk("arith", 64'h1, {63'h0, arith});
        chk("signs", 64'h2, {62'h0, qneg, lneg});
        issue(FLC_OP_CHECK, FLC_SZ_QUAD, 64'h0, 32'h0, 64'h0010_0000_8000_0000, 1'b0, 1'b0);
        chk("no arith", 64'h0, {63'h0, arith});
        chk("signs", 64'h1, {62'h0, qneg, lneg});
    endtask
    task automatic t_fields();
        {mc, write_ignored_field, fw} = {64'h0, 64'h0, 64'h1234_5678_9abc_def0};
        issue(FLC_OP_STORE, FLC_SZ_LONG, 64'h0, 32'h0, 64'h0000_0000_2000_0000, 1'b1, 1'b0);
        chk("store zero", 64'h0, {32'h0, mem_wr});
        chk("store zero flag", 64'h1, {63'h0, zero});
        chk("field write", 64'h1234_5678_9abc_def0, fld);
        chk("no illegal", 64'h0, {63'h0, illop});
        {mc, write_ignored_field, fw} = {64'hff, 64'hffff_ffff_0000_0000, 64'hffff_ffff_ffff_ffff};
        issue(FLC_OP_STORE, FLC_SZ_LONG, 64'h0, 32'h0, 64'h4000_0000_0000_0000, 1'b1, 1'b0);
        chk("store exp", 64'h4000, {32'h0, mem_wr});
        chk("field ignore", 64'h1234_5678_ffff_ff00, fld);
        chk("no illegal", 64'h0, {63'h0, illop});
        mc = 64'h1;
        issue(FLC_OP_LOAD, FLC_SZ_LONG, 64'h0, 32'h4080, 64'h0000_0000_0000_0001, 1'b1, 1'b0);
        chk("illegal", 64'h1, {63'h0, illop});
        chk("field read", 64'h1234_5678_ffff_fffe, fld);
        {mc, write_ignored_field, fw} = '0;
    endtask
    task automatic final_report();
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        {err_total, comparisons} = '0;
        {nrst_i, req, kern, undef, addr, mem_v, reg_v, mc, write_ignored_field, fw} = '0;
        op = FLC_OP_NONE;
        sz = FLC_SZ_BYTE;
        repeat (16) @(posedge clk_i);
        @(negedge clk_i);
        nrst_i = 1'b1;
        t_load();
        t_priv();
        t_store();
        t_align();
        t_check();
        t_fields();
        final_report();
    end
    initial
    begin
        #20000;
        err_total++;
        final_report();
    end
endmodule
